// >>> rtl/brs_down_counter.v
// Loadable down counter that stops at zero.
// Assumes load and dec come from the same clock domain as clk_sys.
module brs_down_counter #(
	parameter W = 3
) (
	// Clock and reset
	input  wire         clk_sys,
	input  wire         rst,
	// Control
	input  wire         load,
	input  wire [W-1:0] load_val,
	input  wire         dec,
	// Count
	output reg  [W-1:0] cnt_ff
);
	localparam [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
	localparam [W-1:0] ZERO = {W{1'b0}};

	always @(posedge clk_sys)
	begin
		if (rst)
			cnt_ff <= ZERO;
		else if (load)
			cnt_ff <= load_val;
		else if (dec && (cnt_ff != ZERO))
			cnt_ff <= cnt_ff - ONE;
	end
endmodule

// >>> rtl/brs_regs.vh
// Constants for the linear burst sequencer: configuration field positions,
// reset value, burst length codes and latency figures.
// Assumes it is included by bare name from the design files.
`ifndef BRS_REGS_VH
`define BRS_REGS_VH

`define BRS_CFG_W              16
`define BRS_CFG_RESET          16'hEFC8
`define BRS_BIT_READ_MODE      15
`define BRS_BIT_BOUNDARY_LAT   14
`define BRS_WAIT_HI            13
`define BRS_WAIT_LO            11
`define BRS_BIT_READY_POL      10
`define BRS_BIT_WRAP           3
`define BRS_LEN_HI             2
`define BRS_LEN_LO             0

`define BRS_LEN_CONT           3'h0
`define BRS_LEN_8              3'h2
`define BRS_LEN_16             3'h3
`define BRS_LEN_32             3'h4
`define BRS_WORDS_8            6'h08
`define BRS_WORDS_16           6'h10
`define BRS_WORDS_32           6'h20

`define BRS_WAIT_MAX           3'h5
`define BRS_EDGE_OFFSET        3'h1
`define BRS_LINE_MASK          7'h7F
`define BRS_BOUNDARY_STALL     3'h1

`endif

// >>> rtl/brs_seq.v
// Burst read address sequencer with its burst configuration register.
// Assumes the host drives ce_n, address_valid_strobe_n and addr_in synchronous to clk_sys,
// and that command decoding outside turns the set/read configuration sequences into pulses.
//
// Operation
// RULE_01: Linear burst outputs 8, 16 or 32 words.
// RULE_02: Groups aligned to the burst length.
// RULE_03: Wrap starts at address, returns to group start.
// RULE_04: Wrap delivers each group word once, ends.
// RULE_05: Wrapped bursts insert no boundary wait states.
// RULE_06: No-wrap burst increments count words, then stops.
// RULE_07: No-wrap burst pays boundary crossing latency.
// RULE_08: Host needs fresh address strobe after burst.
// RULE_09: Reset gives async mode, default configuration.
// RULE_10: Host configures register before burst operations.
// RULE_11: Chip select does not disturb configuration.
// RULE_12: Configuration register can be read back.
// RULE_13: Read mode bit: zero sync, one async.
// RULE_14: Boundary latency bit adds crossing wait state.
// RULE_15: Wait code n: data on edge n+2. Codes above 101 are clamped to 101 here, so 110 and 111 also give edge 7.
// RULE_16: Host picks wait code for its frequency.
// RULE_17: More initial waits, less later latency.
// RULE_18: Ready polarity bit: zero low, one high.
// RULE_19: Length codes 000, 010, 011, 100 decoded.
// RULE_20: Wrap bit: one wraps, zero does not.
// RULE_21: Line boundaries every 128 words.
// RULE_22: Wrap steps only low bits, high fixed.
`include "brs_regs.vh"

module brs_seq #(
	parameter ADDR_W = 24
) (
	// Clock and reset
	input  wire              clk_sys,
	input  wire              rst,
	// Host burst interface
	input  wire              ce_n,
	input  wire              address_valid_strobe_n,
	input  wire [ADDR_W-1:0] addr_in,
	output reg  [ADDR_W-1:0] word_addr_ff,
	output reg               word_valid_ff,
	output reg               rdy_ff,
	output reg               burst_active_ff,
	// Configuration access
	input  wire              cfg_wr,
	input  wire [15:0]       cfg_wdata,
	input  wire              cfg_rd,
	output reg  [15:0]       cfg_rdata_ff,
	output reg  [15:0]       burst_configuration_ff
);
	localparam [3:0] ST_IDLE  = 4'h1;
	localparam [3:0] ST_WAIT  = 4'h2;
	localparam [3:0] ST_DATA  = 4'h4;
	localparam [3:0] ST_STALL = 4'h8;
	localparam [5:0] ONE6     = 6'h01;
	localparam [2:0] ONE3     = 3'h1;
	localparam [ADDR_W-1:0] ONE_A = {{(ADDR_W-1){1'b0}}, 1'b1};

	reg  [3:0]        state_ff;
	reg  [3:0]        nxt_state;
	reg  [ADDR_W-1:0] nxt_word_addr;
	reg               nxt_word_valid;
	reg  [5:0]        words_left_ff;
	reg  [5:0]        nxt_words_left;
	reg               first_ff;
	reg               nxt_first;
	reg  [2:0]        early_stall_ff;
	reg  [2:0]        nxt_early_stall;
	reg               cnt_load;
	reg  [2:0]        cnt_load_val;
	reg               cnt_dec;
	reg  [5:0]        len_words;
	reg  [ADDR_W-1:0] grp_mask;
	reg  [ADDR_W-1:0] step_addr;
	reg  [2:0]        wait_n;
	wire [2:0]        cnt;

	wire       read_async   = burst_configuration_ff[`BRS_BIT_READ_MODE];
	wire       boundary_lat = burst_configuration_ff[`BRS_BIT_BOUNDARY_LAT];
	wire [2:0] wait_code    = burst_configuration_ff[`BRS_WAIT_HI:`BRS_WAIT_LO];
	wire       ready_pol    = burst_configuration_ff[`BRS_BIT_READY_POL];
	wire       wrap_en      = burst_configuration_ff[`BRS_BIT_WRAP];
	wire [2:0] len_code     = burst_configuration_ff[`BRS_LEN_HI:`BRS_LEN_LO];
	wire       continuous   = (len_words == 6'h00);
	wire       latch        = ~ce_n & ~address_valid_strobe_n & ~read_async; // [RULE_13]

	brs_down_counter #(
		.W (3)
	) u_wait_cnt (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.load     (cnt_load),
		.load_val (cnt_load_val),
		.dec      (cnt_dec),
		.cnt_ff   (cnt)
	);

	// Burst length and group mask; reserved codes fall back to plain increments without an end.
	always @*
	begin
		len_words = 6'h00;
		case (len_code)
			`BRS_LEN_8:  len_words = `BRS_WORDS_8;  // [RULE_19] [RULE_01]
			`BRS_LEN_16: len_words = `BRS_WORDS_16; // [RULE_19] [RULE_01]
			`BRS_LEN_32: len_words = `BRS_WORDS_32; // [RULE_19] [RULE_01]
			default:     len_words = 6'h00;
		endcase
		grp_mask = {{(ADDR_W-6){1'b0}}, len_words - ONE6}; // [RULE_02]
		wait_n   = (wait_code > `BRS_WAIT_MAX) ? `BRS_WAIT_MAX : wait_code;
		if (wrap_en && !continuous)
			step_addr = (word_addr_ff & ~grp_mask) | ((word_addr_ff + ONE_A) & grp_mask); // [RULE_03] [RULE_22] [RULE_20]
		else
			step_addr = word_addr_ff + ONE_A; // [RULE_06]
	end

	always @*
	begin
		nxt_state       = state_ff;
		nxt_word_addr   = word_addr_ff;
		nxt_word_valid  = word_valid_ff;
		nxt_words_left  = words_left_ff;
		nxt_first       = first_ff;
		nxt_early_stall = early_stall_ff;
		cnt_load        = 1'b0;
		cnt_load_val    = 3'h0;
		cnt_dec         = 1'b0;
		if (ce_n)
		begin
			nxt_state      = ST_IDLE;
			nxt_word_valid = 1'b0;
		end
		else if (latch)
		begin
			// A new strobe restarts the sequence, even in the middle of a burst.
			nxt_state       = ST_WAIT;
			nxt_word_addr   = addr_in;
			nxt_word_valid  = 1'b0;
			nxt_words_left  = len_words;
			nxt_first       = 1'b1;
			cnt_load        = 1'b1;
			cnt_load_val    = wait_n + `BRS_EDGE_OFFSET; // [RULE_15]
			// Short initial latency leaves the array behind after the first word; a longer one hides it.
			nxt_early_stall = (addr_in[1:0] > wait_n[1:0] && wait_n < 3'h4) ?
				{1'b0, addr_in[1:0]} - wait_n : 3'h0; // [RULE_17]
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
				begin
					nxt_word_valid = 1'b0; // [RULE_08]
				end
				ST_WAIT, ST_STALL:
				begin
					cnt_dec = 1'b1;
					if (cnt == ONE3)
					begin
						nxt_state      = ST_DATA;
						nxt_word_valid = 1'b1; // [RULE_15]
					end
				end
				ST_DATA:
				begin
					nxt_first      = 1'b0;
					nxt_words_left = words_left_ff - ONE6;
					if (!continuous && words_left_ff == ONE6)
					begin
						nxt_state      = ST_IDLE; // [RULE_04] [RULE_06] [RULE_08]
						nxt_word_valid = 1'b0;
					end
					else
					begin
						nxt_word_addr = step_addr;
						if (first_ff && early_stall_ff != 3'h0)
						begin
							nxt_state      = ST_STALL;
							nxt_word_valid = 1'b0;
							cnt_load       = 1'b1;
							cnt_load_val   = early_stall_ff; // [RULE_17]
						end
						else if (!(wrap_en && !continuous) && boundary_lat &&
							((step_addr[6:0] & `BRS_LINE_MASK) == 7'h00))
						begin
							nxt_state      = ST_STALL;
							nxt_word_valid = 1'b0;
							cnt_load       = 1'b1;
							cnt_load_val   = `BRS_BOUNDARY_STALL; // [RULE_07] [RULE_14] [RULE_21] [RULE_05]
						end
					end
				end
				default:
				begin
					nxt_state      = ST_IDLE;
					nxt_word_valid = 1'b0;
				end
			endcase
		end
	end

	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_ff        <= ST_IDLE;
			word_addr_ff    <= {ADDR_W{1'b0}};
			word_valid_ff   <= 1'b0;
			words_left_ff   <= 6'h00;
			first_ff        <= 1'b0;
			early_stall_ff  <= 3'h0;
			burst_active_ff <= 1'b0;
			rdy_ff          <= 1'b0;
		end
		else
		begin
			state_ff        <= nxt_state;
			word_addr_ff    <= nxt_word_addr;
			word_valid_ff   <= nxt_word_valid;
			words_left_ff   <= nxt_words_left;
			first_ff        <= nxt_first;
			early_stall_ff  <= nxt_early_stall;
			burst_active_ff <= (nxt_state != ST_IDLE);
			// Polarity is taken from the current register; a change shows on the next edge.
			rdy_ff          <= ready_pol ? nxt_word_valid : ~nxt_word_valid; // [RULE_18]
		end
	end

	// The configuration register ignores chip select so settings survive deselection.
	always @(posedge clk_sys)
	begin
		if (rst)
		begin
			burst_configuration_ff <= `BRS_CFG_RESET; // [RULE_09]
			cfg_rdata_ff           <= 16'h0000;
		end
		else
		begin
			if (cfg_wr)
				burst_configuration_ff <= cfg_wdata; // [RULE_11]
			if (cfg_rd)
				cfg_rdata_ff <= burst_configuration_ff; // [RULE_12]
		end
	end
endmodule

// >>> test/brs_host.sv
// Host controller model: one synchronous burst read per go pulse.
// Assumes the configuration is written first and pol gives the active ready level.
module brs_host (
	// Control
	input logic		clk_sys,
	input logic		go,
	input logic [23:0]	start,
	input logic		pol,
	// Device side
	input logic [23:0]	word_addr_ff,
	input logic		rdy_ff,
	input logic		burst_active_ff,
	output logic		ce_n,
	output logic		address_valid_strobe_n,
	output logic [23:0]	addr_in,
	// Result
	output int		n,
	output logic		done,
	output logic [23:0]	seen [0:63]
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		ce_n = 1'b1;
		address_valid_strobe_n = 1'b1;
		addr_in = 24'h000000;
		done = 1'b0;
		forever
		begin
			@(posedge clk_sys);
			if (go === 1'b1)
			begin
				ce_n <= 1'b0;
				address_valid_strobe_n <= 1'b0;
				addr_in <= start;
				n = 0;
				done <= 1'b0;
				@(posedge clk_sys);
				address_valid_strobe_n <= 1'b1;
				// A released bus shows the inverse so a stale address cannot pass.
				addr_in <= ~start;
				repeat (64)
				begin
					@(posedge clk_sys);
					if (rdy_ff === pol)
					begin
						seen[n] = word_addr_ff;
						n++;
					end
					else if (burst_active_ff !== 1'b1)
						break;
				end
				ce_n <= 1'b1;
				done <= 1'b1;
			end
		end
	end
endmodule

// >>> test/brs_seq_assertions.sv
// Port-level checker for the burst sequencer.
// Assumes it is bound onto brs_seq from the bench top.
module brs_seq_assertions #(
	parameter ADDR_W = 24
) (
	// Clock and reset
	input logic			clk_sys,
	input logic			rst,
	// Burst side
	input logic			ce_n,
	input logic			address_valid_strobe_n,
	input logic [ADDR_W-1:0]	addr_in,
	input logic [ADDR_W-1:0]	word_addr_ff,
	input logic			word_valid_ff,
	input logic			rdy_ff,
	input logic			burst_active_ff,
	// Configuration
	input logic			cfg_wr,
	input logic [15:0]		cfg_wdata,
	input logic			cfg_rd,
	input logic [15:0]		cfg_rdata_ff,
	input logic [15:0]		burst_configuration_ff
);
	logic [15:0]	c;
	logic		v;
	logic		take;
	assign c = burst_configuration_ff;
	assign v = word_valid_ff;
	assign take = !ce_n && !address_valid_strobe_n && !burst_active_ff && !c[15];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_RESET: assert property (disable iff (1'b0) rst |=> !v && !rdy_ff && !burst_active_ff && c == 16'hEFC8)
		else $error("bad reset state");
	AST_READ: assert property (cfg_rd |=> cfg_rdata_ff == $past(c))
		else $error("bad readback");
	AST_POL: assert property ($stable(c[10]) |-> rdy_ff == (c[10] ? v : !v))
		else $error("bad ready level");
	AST_LAT5: assert property (take && c[13:11] == 3'h5 |=> !v [*6] ##1 v)
		else $error("bad first latency");
	AST_WRAP8: assert property (v && $past(v) && c[3] && c[2:0] == 3'h2 |-> word_addr_ff[2:0] ==
		$past(word_addr_ff[2:0]) + 3'h1 && word_addr_ff[ADDR_W-1:3] == $past(word_addr_ff[ADDR_W-1:3]))
		else $error("bad wrap step");
	AST_STEP: assert property (v && $past(v) && !c[3] |-> word_addr_ff == $past(word_addr_ff) + 1'b1)
		else $error("bad linear step");
	AST_WRAPLEN: assert property ($rose(v) && c[3] && c[2:0] == 3'h2 && c[13:11] == 3'h5 |-> v [*8] ##1 !v)
		else $error("bad wrap length");
	AST_CROSS: assert property (v && !c[3] && c[14] && word_addr_ff[6:0] == 7'h7F |=> !v ##1 v)
		else $error("no crossing stall");
	AST_EARLY: assert property (take && c[13:11] == 3'h2 && addr_in[1:0] == 2'h3 |=> !v [*3] ##1 v ##1 !v ##1 v)
		else $error("bad stall after first word");
	cover property (take);
	cover property (v && !c[3] && word_addr_ff[6:0] == 7'h7F);
	cover property ($fell(burst_active_ff));
endmodule

// >>> test/tb_top.sv
// Bench for the burst sequencer: a table of bursts, then readback and reset cases.
// Assumes the host model and the checker are compiled before it.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam ADDR_W = 24;
	logic		clk_sys, rst, cfg_wr, cfg_rd, go, done, ce_n, address_valid_strobe_n;
	logic		word_valid_ff, rdy_ff, burst_active_ff;
	logic [15:0]	cfg_wdata, cfg_rdata_ff, burst_configuration_ff;
	logic [23:0]	start, addr_in, word_addr_ff, m, e;
	logic [23:0]	seen [0:63];
	int		n, fail_count = 0, check_count = 0, cyc = 0;
	// Rows: configuration, start address, word count.
	// Row 6 is continuous with no crossing latency, so it never ends by itself: the host closes it after
	// 64 sampling edges, which leaves 63 words at wait code 000 and would leave fewer if a stall crept in.
	logic [15:0]	rc [0:7] = '{16'h07CA, 16'h6FCB, 16'h6BCC, 16'h6FC2, 16'h17C2, 16'h5FC3, 16'h07C0, 16'h6FCA};
	logic [23:0]	ra [0:7] = '{24'h00003C, 24'h123456, 24'h00005B, 24'h00007C, 24'h00003F, 24'h0000F5, 24'h000070,
		24'h00007D};
	logic [23:0]	rn [0:7] = '{24'h8, 24'h10, 24'h20, 24'h8, 24'h8, 24'h10, 24'h3F, 24'h8};
	brs_seq #(.ADDR_W(ADDR_W)) brs_seq_i (.clk_sys, .rst, .ce_n, .address_valid_strobe_n, .addr_in, .word_addr_ff,
		.word_valid_ff, .rdy_ff, .burst_active_ff, .cfg_wr, .cfg_wdata, .cfg_rd, .cfg_rdata_ff, .burst_configuration_ff);
	brs_host brs_host_i (.clk_sys, .go, .start, .pol(cfg_wdata[10]), .word_addr_ff, .rdy_ff, .burst_active_ff,
		.ce_n, .address_valid_strobe_n, .addr_in, .n, .done, .seen);
	task check(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task wr_cfg(input logic [15:0] val);
		@(posedge clk_sys);
		cfg_wr <= 1'b1;
		cfg_wdata <= val;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
	endtask
	task burst(input logic [23:0] a);
		@(posedge clk_sys);
		go <= 1'b1;
		start <= a;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (200)
		begin
			@(posedge clk_sys);
			if (done === 1'b1)
				break;
		end
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			end_sim();
		end
	end
	initial
	begin
		rst = 1'b1;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		go = 1'b0;
		start = 24'h000000;
		cfg_wdata = 16'hEFC8;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		// Every row keeps its wait code within 000 to 101; at this clock any of them is fast enough.
		for (int i = 0; i < 8; i++)
		begin
			wr_cfg(rc[i]);
			burst(ra[i]);
			check(24'(n), rn[i]);
			m = rn[i] - 24'h1;
			for (int j = 0; j < rn[i]; j++)
			begin
				e = rc[i][3] ? (ra[i] & ~m) | ((ra[i] + 24'(j)) & m) : ra[i] + 24'(j);
				check(seen[j], e);
			end
			$display("burst row %0d done", i);
		end
		// Chip select has toggled around every burst, so the register must still hold.
		cfg_rd <= 1'b1;
		@(posedge clk_sys);
		cfg_rd <= 1'b0;
		@(posedge clk_sys);
		check({8'h00, cfg_rdata_ff}, 24'h006FCA);
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		check({8'h00, burst_configuration_ff}, 24'h00EFC8);
		check({8'h00, cfg_rdata_ff}, 24'h000000);
		burst(24'h00003C);
		check(24'(n), 24'h000000);
		$display("readback and reset tests done");
		end_sim();
	end
endmodule
bind brs_seq brs_seq_assertions #(.ADDR_W(ADDR_W)) brs_seq_assertions_i (.clk_sys, .rst, .ce_n, .address_valid_strobe_n,
	.addr_in, .word_addr_ff, .word_valid_ff, .rdy_ff, .burst_active_ff, .cfg_wr, .cfg_wdata, .cfg_rd, .cfg_rdata_ff,
	.burst_configuration_ff);
